// File: design/sram_port_ctrl.sv
/*
  Host-side controller for an asynchronous 1M x 16 static memory.
  Takes one read or write request at a time and sequences the pins.
  Assumes the memory pins are sampled and driven synchronously to mclk
  and that board delays are well below one clock period.
*/
`timescale 1ns/1ns
// Function
// [R01] Memory idles deselected: select high, lanes off
// [R02] Memory floats data when deselected or writing
// [R03] Write: selects active, write strobe low
// [R04] Lane enables pick stored bytes on write
// [R05] Read: selects active, gate low, strobe high
// [R06] Read drives only enabled lanes
// [R07] Array is 1M words, 20-bit address
// [R08] No drive glitch when deselect ends write
// [R09] Controller never drives data while memory might
// [R10] Write window is strobe, select, lane overlap
// [R11] Read sampled no sooner than read cycle
// [R12] Old data held briefly after address change
// [R13] Read data valid soon after gate falls
// [R14] Address held through write and after end
// [R15] Write data set up before window closes
// [R16] Address valid before selects and lanes activate
// [R17] Joint lane toggle shortens low-Z delay
module sram_port_ctrl
  import sram_port_pkg::*;
#(
  parameter int RD_CYCLES = RD_CYC,
  parameter int WR_CYCLES = WR_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // User request
  input wire logic req_valid,
  output logic req_ready,
  input wire sram_req_t req,
  // User read answer
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_data,
  // Memory pins
  output sram_ctl_t ctl,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [DATA_W-1:0] mem_dq_out,
  output logic mem_dq_oe,
  input wire logic [DATA_W-1:0] mem_dq_in
);

  // Sequencer states
  typedef enum logic [2:0] {S_IDLE, S_SETUP, S_READ, S_WRITE, S_HOLD, S_TURN} state_t;

  state_t state_q; // Current state
  logic [CNT_W-1:0] cnt_q; // Cycles left in a phase
  sram_req_t cur_q; // Latched request
  sram_ctl_t ctl_q; // Registered control pins
  logic dq_oe_q; // Registered data drive enable
  logic rsp_valid_q; // Read answer strobe
  logic [DATA_W-1:0] rsp_data_q; // Captured read data
  // Idle pin levels: deselected, strobe and gate high, both lanes off
  localparam sram_ctl_t CTL_IDLE = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};

  // Merge the read lanes: unselected lane reads zero
  function automatic logic [DATA_W-1:0] lane_merge(input logic [1:0] lanes,
                                                   input logic [DATA_W-1:0] d);
    lane_merge = {lanes[1] ? d[DATA_W-1:LANE_W] : {LANE_W{1'b0}},
                  lanes[0] ? d[LANE_W-1:0] : {LANE_W{1'b0}}};
  endfunction : lane_merge

  assign req_ready = (state_q == S_IDLE);
  assign ctl = ctl_q;
  assign mem_addr = cur_q.addr;
  assign mem_dq_out = cur_q.wdata;
  assign mem_dq_oe = dq_oe_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_data = rsp_data_q;

  // Phase sequencer
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q <= S_IDLE;
      cnt_q <= '0;
    end else begin
      case (state_q)
        S_IDLE: begin
          // Zero-lane requests are dropped: nothing to move
          if (req_valid && req.lanes != 2'h0) begin
            state_q <= S_SETUP;
          end
        end
        S_SETUP: begin
          // Address settles one cycle before any select, see [R16]
          state_q <= cur_q.write ? S_WRITE : S_READ;
          cnt_q <= cur_q.write ? CNT_W'(WR_CYCLES - 1) : CNT_W'(RD_CYCLES - 1);
        end
        S_READ: begin
          // Full read cycle before sampling, see [R11]
          if (cnt_q == '0) begin
            state_q <= S_TURN;
            cnt_q <= CNT_W'(TURN_CYC - 1);
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        S_WRITE: begin
          // Strobe held long enough for address and data set-up, see [R14]
          if (cnt_q == '0) begin
            state_q <= S_HOLD;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        S_HOLD: state_q <= S_IDLE; // Address and data held past write end
        S_TURN: begin
          // Let memory outputs float before the next access
          if (cnt_q == '0) begin
            state_q <= S_IDLE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Request capture; address stays put until the next request, see [R14]
  always_ff @(posedge mclk) begin
    if (reset) begin
      cur_q <= '0;
    end else if (state_q == S_IDLE && req_valid) begin
      cur_q <= req;
    end
  end

  // Control pins, registered so they never glitch
  always_ff @(posedge mclk) begin
    if (reset) begin
      ctl_q <= CTL_IDLE; // Deselected, see [R01]
    end else begin
      ctl_q <= CTL_IDLE;
      case (state_q)
        S_SETUP: begin
          // Selects and lanes go active together with the gate for a read or the strobe for a write
          ctl_q.primary_select_n <= 1'b0;
          ctl_q.secondary_select <= 1'b1;
          {ctl_q.upper_lane_enable_n, ctl_q.lower_lane_enable_n} <= ~cur_q.lanes; // see [R04]
          ctl_q.write_strobe_n <= ~cur_q.write; // see [R03] [R10]
          ctl_q.output_gate_n <= cur_q.write; // see [R05]
        end
        S_READ, S_WRITE: begin
          ctl_q <= ctl_q; // Hold the access
          if (state_q == S_READ && cnt_q == '0) begin
            ctl_q <= CTL_IDLE;
          end
          if (state_q == S_WRITE && cnt_q == '0) begin
            // Strobe and select rise together; memory stays floating, see [R08]
            ctl_q <= CTL_IDLE;
          end
        end
        default: ;
      endcase
    end
  end

  // Data bus drive: while the strobe is low and one cycle after it, see [R09] [R15]
  always_ff @(posedge mclk) begin
    if (reset) begin
      dq_oe_q <= 1'b0;
    end else begin
      // Drive spans the strobe plus one cycle of data hold after it rises
      dq_oe_q <= (state_q == S_SETUP && cur_q.write) || (state_q == S_WRITE);
    end
  end

  // Read data capture at the end of the read cycle, see [R06] [R13]
  always_ff @(posedge mclk) begin
    if (reset) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q <= '0;
    end else begin
      rsp_valid_q <= (state_q == S_READ && cnt_q == '0);
      if (state_q == S_READ && cnt_q == '0) begin
        rsp_data_q <= lane_merge(cur_q.lanes, mem_dq_in);
      end
    end
  end

  // Named steps of a write
  sequence write_start_s;
    state_q == S_SETUP && cur_q.write;
  endsequence
  sequence write_body_s;
    !ctl.write_strobe_n && !ctl.primary_select_n && mem_dq_oe;
  endsequence

  // Deselected whenever idle
  idle_deselect_a: assert property (@(posedge mclk) disable iff (reset) // see [R01]
    state_q == S_IDLE |-> ctl.primary_select_n) else $error("select active while idle");

  // Write window lasts the full count with data driven
  write_window_a: assert property (@(posedge mclk) disable iff (reset) // see [R10]
    write_start_s |=> write_body_s [*3]) else $error("write window too short");

  // Data setup covers the strobe
  data_drive_a: assert property (@(posedge mclk) disable iff (reset) // see [R15]
    !ctl.write_strobe_n |-> mem_dq_oe) else $error("strobe low without data");

  // Never drive while the gate is low
  no_clash_a: assert property (@(posedge mclk) disable iff (reset) // see [R09]
    !ctl.output_gate_n |-> !mem_dq_oe) else $error("bus clash on read");

  // Read answer after full read cycle
  read_answer_a: assert property (@(posedge mclk) disable iff (reset) // see [R11]
    (state_q == S_SETUP && !cur_q.write) |-> ##6 rsp_valid) else $error("read answer late");

  // Address stable across the write
  addr_hold_a: assert property (@(posedge mclk) disable iff (reset) // see [R14]
    (!ctl.write_strobe_n && !$past(ctl.write_strobe_n)) |-> $stable(mem_addr))
    else $error("address moved in write");

  // Gate and strobe never low together
  mode_excl_a: assert property (@(posedge mclk) disable iff (reset) // see [R03]
    !(!ctl.output_gate_n && !ctl.write_strobe_n)) else $error("read and write at once");

  // Lanes active only when selected
  lane_select_a: assert property (@(posedge mclk) disable iff (reset) // see [R16]
    (!ctl.lower_lane_enable_n || !ctl.upper_lane_enable_n) |-> !ctl.primary_select_n)
    else $error("lane without select");

endmodule : sram_port_ctrl

// File: shared/sram_port_pkg.sv
/*
  Package for the static memory port controller: pin bundles, request
  types, and timing figures with their derived cycle counts.
  Assumes a 50 MHz controller clock and the slow speed grade.
*/
package sram_port_pkg;
  // Controller clock period in ns
  localparam int CLK_PERIOD_NS = 20;
  // Memory geometry
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int LANE_W = 8;
  // Slow-grade timing figures, ns
  localparam int T_READ_CYCLE_NS = 70;
  localparam int T_ADDR_DATA_NS = 70;
  localparam int T_GATE_DATA_NS = 35;
  localparam int T_ADDR_TO_END_NS = 60;
  localparam int T_DATA_SETUP_NS = 30;
  localparam int T_OUT_FLOAT_NS = 25;
  // Least times rounded up to whole cycles, plus one for the read count
  localparam int RD_CYC = (T_ADDR_DATA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int WR_CYC = (T_ADDR_TO_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DS_CYC = (T_DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TURN_CYC = (T_OUT_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  // Idle pin levels
  localparam logic [1:0] LANES_OFF = 2'h3;

  // Control pins toward the memory
  typedef struct packed {
    logic primary_select_n;
    logic secondary_select;
    logic write_strobe_n;
    logic output_gate_n;
    logic upper_lane_enable_n;
    logic lower_lane_enable_n;
  } sram_ctl_t;

  // User request bundle
  typedef struct packed {
    logic write;
    logic [1:0] lanes;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } sram_req_t;
endpackage : sram_port_pkg

// File: tb/sram_dev_model.sv
/*
  Behavioural model of the 1M x 16 static memory at the far side of the
  port controller. Assumes the controller changes pins just after mclk
  rises, so pins are steady at the falling edge.
*/
`timescale 1ns/1ns
module sram_dev_model
  import sram_port_pkg::*;
(
  // Clock used only to pace the model
  input wire logic mclk,
  // Pins from the controller
  input wire sram_ctl_t ctl,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [DATA_W-1:0] mem_dq_out,
  // Data driven back, one enable per lane
  output logic [DATA_W-1:0] dev_dq,
  output logic [1:0] dev_oe
);
  // Sparse store: a full 1M array would waste simulator memory
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic sel; // Chip selected
  logic [1:0] lane; // Lanes enabled, bit1 upper
  logic [DATA_W-1:0] w; // Word being merged
  assign sel = !ctl.primary_select_n && ctl.secondary_select;
  assign lane = ~{ctl.upper_lane_enable_n, ctl.lower_lane_enable_n};
  // Store only inside the overlap window
  always @(negedge mclk) begin
    if (sel && !ctl.write_strobe_n && lane != 2'h0) begin
      w = mem.exists(mem_addr) ? mem[mem_addr] : 16'h0;
      if (lane[0]) w[7:0] = mem_dq_out[7:0];
      if (lane[1]) w[15:8] = mem_dq_out[15:8];
      mem[mem_addr] = w;
    end
    // Old word stays half a cycle after an address change
    dev_dq <= mem.exists(mem_addr) ? mem[mem_addr] : 16'h0;
  end
  // Drive only enabled lanes in a read; float otherwise
  // Gate high at a write end keeps lanes floating
  // Lanes turn on within the cycle the gate or lanes go low
  assign dev_oe = (sel && ctl.write_strobe_n && !ctl.output_gate_n) ? lane : 2'h0;
endmodule : sram_dev_model

// File: tb/async_sram_16bit_port_test.sv
/*
  Self-checking bench for the static memory port controller.
  Assumes the device model in tb/ and the package in shared/.
*/
`timescale 1ns/1ns
module async_sram_16bit_port_test;
  import sram_port_pkg::*;
  logic mclk, reset, req_valid, req_ready, rsp_valid, mem_dq_oe;
  sram_req_t req;
  sram_ctl_t ctl;
  logic [DATA_W-1:0] rsp_data, mem_dq_out, mem_dq_in, dev_dq;
  logic [DATA_W-1:0] flt = 16'h5A3C; // Pattern seen on undriven lanes
  logic [ADDR_W-1:0] mem_addr;
  logic [1:0] dev_oe;
  int fail_count, checks;
  sram_port_ctrl DUT (.mclk(mclk), .reset(reset), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .ctl(ctl), .mem_addr(mem_addr), .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe),
    .mem_dq_in(mem_dq_in));
  sram_dev_model mem_model (.mclk(mclk), .ctl(ctl), .mem_addr(mem_addr),
    .mem_dq_out(mem_dq_out), .dev_dq(dev_dq), .dev_oe(dev_oe));
  // Undriven lanes toggle so a stale value never passes
  always @(posedge mclk) flt <= ~flt;
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      mem_dq_in[i*8+:8] = dev_oe[i] ? dev_dq[i*8+:8] :
        mem_dq_oe ? mem_dq_out[i*8+:8] : flt[i*8+:8];
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict;
    if (fail_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict
  // One request; returns cycles from take to answer or ready
  task automatic issue(input logic wr, input logic [1:0] ln, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d, output int lat);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge mclk);
      n++;
    end
    req = '{write: wr, lanes: ln, addr: a, wdata: d};
    req_valid = 1'b1;
    @(negedge mclk);
    req_valid = 1'b0;
    // A zero-lane request is dropped at once, so ready never falls
    check("busy", req_ready, ln == 2'h0);
    lat = 1;
    while (rsp_valid !== 1'b1 && req_ready !== 1'b1 && lat < 50) begin
      @(negedge mclk);
      lat++;
    end
  endtask : issue
  task automatic wr(input logic [1:0] ln, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int lat;
    issue(1'b1, ln, a, d, lat);
    // Setup, strobe cycles and one hold cycle before ready returns
    check("wr_lat", lat, (ln == 2'h0) ? 1 : WR_CYC + 3);
  endtask : wr
  task automatic rd(input logic [1:0] ln, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    int lat;
    issue(1'b0, ln, a, 16'h0, lat);
    // Setup cycle plus full read cycle, answer seen half a cycle later
    check("rd_lat", lat, RD_CYC + 2);
    check("rd_data", rsp_data, e);
    @(negedge mclk);
    check("rsp_pulse", rsp_valid, 1'b0);
    check("rsp_hold", rsp_data, e);
  endtask : rd
  // Idle pins after reset: deselected, data released
  task automatic t_reset;
    check("ctl_idle", ctl, 6'h2F);
    check("dq_oe", mem_dq_oe, 1'b0);
    check("ready", req_ready, 1'b1);
  endtask : t_reset
  // Extreme addresses must not alias
  task automatic t_full;
    wr(2'h3, 20'hFFFFF, 16'hA55A);
    wr(2'h3, 20'h00000, 16'h1234);
    rd(2'h3, 20'hFFFFF, 16'hA55A);
  endtask : t_full
  // Single-lane writes and reads
  task automatic t_lanes;
    wr(2'h2, 20'hFFFFF, 16'hC377);
    rd(2'h3, 20'hFFFFF, 16'hC35A);
    rd(2'h1, 20'hFFFFF, 16'h005A);
    rd(2'h2, 20'hFFFFF, 16'hC300);
    wr(2'h1, 20'h00000, 16'hEE99);
    rd(2'h3, 20'h00000, 16'h1299);
  endtask : t_lanes
  // No lanes enabled: memory stays deselected, nothing stored
  task automatic t_none;
    wr(2'h0, 20'h00000, 16'hFFFF);
    check("ctl_none", ctl, 6'h2F);
    rd(2'h3, 20'h00000, 16'h1299);
  endtask : t_none
  // Clock, 50 MHz
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Watchdog well past the expected run
  initial begin
    repeat (3000) @(posedge mclk);
    fail_count++;
    give_verdict();
  end
  // Main sequence
  initial begin
    reset = 1'b1;
    req_valid = 1'b0;
    req = '0;
    repeat (3) @(negedge mclk);
    reset = 1'b0;
    @(negedge mclk);
    t_reset();
    t_full();
    t_lanes();
    t_none();
    give_verdict();
  end
endmodule : async_sram_16bit_port_test
